// *** logic/pmt_cfg.svh ***
// constants for the program memory table pointer unit
// assumes inclusion by bare name from every file that needs them
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

// pointer geometry
`define PMT_PTR_W 22
`define PMT_LOW_W 21
`define PMT_CFG_BIT 21
`define PMT_SEL_W 6
`define PMT_SEL_MIN 3
`define PMT_SEL_MAX 6
`define PMT_ERASE_LSB 6

// register port
`define PMT_ADDR_W 3
`define PMT_OFS_PTR_LOW 3'h0
`define PMT_OFS_PTR_HIGH 3'h1
`define PMT_OFS_PTR_UPPER 3'h2
`define PMT_OFS_LATCH 3'h3
`define PMT_OFS_STATUS 3'h4

// reset and fill values
`define PMT_ONES 8'hff
`define PMT_ZERO8 8'h00
`define PMT_PTR_RST 22'h00_0000
`define PMT_UPPER_PAD 2'h0

`endif

// *** logic/pmt_pkg.sv ***
// types shared by the table pointer unit and its holding buffer
// assumes pmt_cfg.svh is on the include path
`default_nettype none
`include "pmt_cfg.svh"

package pmt_pkg;

  // pointer update applied by one table operation
  typedef enum logic [1:0] {
    PMT_MODE_KEEP     = 2'b00,
    PMT_MODE_POST_INC = 2'b01,
    PMT_MODE_POST_DEC = 2'b10,
    PMT_MODE_PRE_INC  = 2'b11
  } pmt_mode_e;

  // sequencer states
  typedef enum logic [1:0] {
    PMT_ST_IDLE     = 2'b00,
    PMT_ST_RD_ISSUE = 2'b01,
    PMT_ST_RD_WAIT  = 2'b10,
    PMT_ST_PROG     = 2'b11
  } pmt_state_e;

  // one table operation from the core
  typedef struct packed {
    logic is_write;
    pmt_mode_e mode;
  } pmt_op_s;

  // one byte write toward the flash array
  typedef struct packed {
    logic cfg_space;
    logic [`PMT_LOW_W-1:0] byte_addr;
    logic [7:0] data;
  } pmt_flash_wr_s;

endpackage : pmt_pkg
`default_nettype wire

// *** logic/pmt_hold_mem.sv ***
// write-block holding buffer, one byte per entry
// assumes one clock; read data come from a register one cycle after raddr_i
`timescale 1ns/100ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_hold_mem
  import pmt_pkg::*;
#(
  parameter int SEL_W = `PMT_SEL_W
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clear_i,
  input wire logic wr_i,
  input wire logic [SEL_W-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // read side
  input wire logic [SEL_W-1:0] raddr_i,
  output logic [7:0] rdata_o
);

  localparam int DEPTH = 1 << SEL_W;

  logic [7:0] mem_q [DEPTH];

  // per-entry storage, erased to all ones on reset and after programming
  for (genvar e = 0; e < DEPTH; e++)
  begin : g_entry
    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
        mem_q[e] <= `PMT_ONES;
      else if (clear_i)
        mem_q[e] <= `PMT_ONES;
      else if (wr_i && (waddr_i == SEL_W'(e)))
        mem_q[e] <= wdata_i;
    end
  end

  // registered read port
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= `PMT_ONES;
    else
      rdata_o <= mem_q[raddr_i];
  end

endmodule : pmt_hold_mem
`default_nettype wire

// *** logic/pmt_table_unit.sv ***
// program memory table pointer unit: pointer, transfer latch, holding buffer
// assumes a core that waits on op_ready_o, and a flash array with a
// one-cycle read latency that accepts a byte write every cycle
//
// What this block does
// [RULE_01] The byte pointer is upper, high and low pointer bytes joined into one 22-bit program address.
// [RULE_02] The low 21 pointer bits pick a byte within up to 2 Mbytes of program space.
// [RULE_03] With the top pointer bit set, accesses go to the identification and configuration space.
// [RULE_04] Automatic increments and decrements touch only the low 21 bits and keep the top bit.
// [RULE_05] A table read uses all 22 pointer bits to fetch one byte into the transfer latch.
// [RULE_06] A table write leaves the flash alone and puts the latch byte into one holding register.
// [RULE_07] Only the low select bits of the low pointer byte pick the holding register on a table write.
// [RULE_08] A block program copies the whole holding buffer to the block named by the upper pointer bits.
// [RULE_09] A block erase clears the 64-byte block named by pointer bits 21 to 6, ignoring bits 5 to 0.
// [RULE_10] Every table operation applies one mode: keep, post-increment, post-decrement or pre-increment.
// [RULE_11] Program memory is 16-bit words and pointer bit 0 picks the high or low byte.
// [RULE_12] The transfer latch is an 8-bit software register carrying bytes both ways.
// [RULE_13] Holding registers are all ones after reset and after programming, and all-ones bytes are not written.
// [RULE_14] The holding buffer has exactly one byte per byte of a programming block of 2^SEL_W bytes, 64 at the default select width of 6.
// [RULE_15] The select width is a parameter and pointer steps wrap inside the low 21 bits.
// [RULE_16] The core finishes each table operation before it starts the next one.
`timescale 1ns/100ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_table_unit
  import pmt_pkg::*;
#(
  parameter int SEL_W = `PMT_SEL_W
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [`PMT_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // table operations from the core
  input wire logic op_valid_i,
  input wire pmt_op_s op_i,
  output logic op_ready_o,
  // block program and erase commands
  input wire logic prog_start_i,
  input wire logic erase_start_i,
  output logic prog_done_o,
  // flash read port
  output logic fl_rd_o,
  output logic fl_rd_cfg_o,
  output logic [`PMT_LOW_W-2:0] fl_rd_word_o,
  input wire logic [15:0] fl_rdata_i,
  // flash write and erase port
  output logic fl_wr_o,
  output pmt_flash_wr_s fl_wr_data_o,
  output logic fl_erase_o,
  output logic [`PMT_PTR_W-`PMT_ERASE_LSB-1:0] fl_erase_block_o
);

  // ************************************************************
  // parameter check
  // ************************************************************

  // the holding select field cannot be narrower than 3 bits nor pass the erase block
  if (SEL_W < `PMT_SEL_MIN || SEL_W > `PMT_SEL_MAX)
  begin : g_bad_sel
    $error("pmt_table_unit: SEL_W out of range");
  end

  localparam int DEPTH = 1 << SEL_W;
  localparam int CNT_W = SEL_W + 1;
  localparam logic [CNT_W-1:0] CNT_END = CNT_W'(DEPTH);
  localparam int BLK_W = `PMT_PTR_W - SEL_W;

  // ************************************************************
  // state
  // ************************************************************

  logic [`PMT_PTR_W-1:0] ptr_q;
  logic [7:0] latch_q;
  pmt_state_e state_q;
  logic rd_cfg_q;
  logic [`PMT_LOW_W-2:0] rd_word_q;
  logic rd_hi_q;
  logic [CNT_W-1:0] cnt_q;
  logic stage_vld_q;
  logic [SEL_W-1:0] stage_idx_q;
  logic [BLK_W-1:0] blk_q;
  logic dirty_q;
  logic hold_clear;
  logic [7:0] hold_rdata;

  logic idle;
  logic op_take;
  logic prog_take;
  logic erase_take;
  logic [`PMT_PTR_W-1:0] ptr_inc;
  logic [`PMT_PTR_W-1:0] ptr_dec;
  logic [`PMT_PTR_W-1:0] ptr_eff;
  logic [`PMT_PTR_W-1:0] ptr_next;

  // ************************************************************
  // pointer arithmetic
  // ************************************************************

  // steps wrap inside the low field; the space select bit rides along unchanged
  assign ptr_inc = {ptr_q[`PMT_CFG_BIT], ptr_q[`PMT_LOW_W-1:0] + `PMT_LOW_W'(1)}; // RULE_04 RULE_15
  assign ptr_dec = {ptr_q[`PMT_CFG_BIT], ptr_q[`PMT_LOW_W-1:0] - `PMT_LOW_W'(1)}; // RULE_04 RULE_15

  // address used by the access itself
  always_comb
  begin
    ptr_eff = ptr_q;
    if (op_i.mode == PMT_MODE_PRE_INC)
      ptr_eff = ptr_inc; // RULE_10
  end

  // pointer after the access
  always_comb
  begin
    case (op_i.mode)
      PMT_MODE_KEEP: ptr_next = ptr_q; // RULE_10
      PMT_MODE_POST_INC: ptr_next = ptr_inc; // RULE_10
      PMT_MODE_POST_DEC: ptr_next = ptr_dec; // RULE_10
      PMT_MODE_PRE_INC: ptr_next = ptr_inc; // RULE_10
      default: ptr_next = ptr_q;
    endcase
  end

  // ************************************************************
  // acceptance
  // ************************************************************

  // one thing at a time; a table op beats program, program beats erase
  assign idle = (state_q == PMT_ST_IDLE);
  assign op_ready_o = idle; // RULE_16
  assign op_take = idle && op_valid_i;
  assign prog_take = idle && !op_valid_i && prog_start_i;
  assign erase_take = idle && !op_valid_i && !prog_start_i && erase_start_i;

  // ************************************************************
  // pointer register
  // ************************************************************

  // a table op overrides a software write landing in the same cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ptr_q <= `PMT_PTR_RST;
    else if (op_take)
      ptr_q <= ptr_next; // RULE_10
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `PMT_OFS_PTR_LOW: ptr_q[7:0] <= reg_wdata_i; // RULE_01
        `PMT_OFS_PTR_HIGH: ptr_q[15:8] <= reg_wdata_i; // RULE_01
        `PMT_OFS_PTR_UPPER: ptr_q[`PMT_PTR_W-1:16] <= reg_wdata_i[`PMT_PTR_W-17:0]; // RULE_01
        default: ptr_q <= ptr_q;
      endcase
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_q <= PMT_ST_IDLE;
    else
    begin
      case (state_q)
        PMT_ST_IDLE:
        begin
          if (op_take && !op_i.is_write)
            state_q <= PMT_ST_RD_ISSUE;
          else if (prog_take)
            state_q <= PMT_ST_PROG;
        end
        PMT_ST_RD_ISSUE: state_q <= PMT_ST_RD_WAIT;
        PMT_ST_RD_WAIT: state_q <= PMT_ST_IDLE;
        PMT_ST_PROG:
        begin
          if (cnt_q == CNT_END)
            state_q <= PMT_ST_IDLE;
        end
        default: state_q <= PMT_ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // table read path
  // ************************************************************

  // read address captured at acceptance, so later pointer writes cannot disturb it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_cfg_q <= 1'b0;
      rd_word_q <= '0;
      rd_hi_q <= 1'b0;
    end
    else if (op_take && !op_i.is_write)
    begin
      rd_cfg_q <= ptr_eff[`PMT_CFG_BIT]; // RULE_03 RULE_05
      rd_word_q <= ptr_eff[`PMT_LOW_W-1:1]; // RULE_02 RULE_05
      rd_hi_q <= ptr_eff[0]; // RULE_11
    end
  end

  assign fl_rd_o = (state_q == PMT_ST_RD_ISSUE);
  assign fl_rd_cfg_o = rd_cfg_q; // RULE_03
  assign fl_rd_word_o = rd_word_q;

  // transfer latch: the fetched byte wins over a software write in the same cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      latch_q <= `PMT_ZERO8;
    else if (state_q == PMT_ST_RD_WAIT)
      latch_q <= rd_hi_q ? fl_rdata_i[15:8] : fl_rdata_i[7:0]; // RULE_05 RULE_11
    else if (reg_wr_i && reg_addr_i == `PMT_OFS_LATCH)
      latch_q <= reg_wdata_i; // RULE_12
  end

  // ************************************************************
  // holding buffer and block program
  // ************************************************************

  // a table write only fills the buffer; the flash is untouched until a program
  pmt_hold_mem #(
    .SEL_W(SEL_W)
  ) u_hold (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(hold_clear), // RULE_13
    .wr_i(op_take && op_i.is_write), // RULE_06 RULE_14
    .waddr_i(ptr_eff[SEL_W-1:0]), // RULE_07
    .wdata_i(latch_q), // RULE_06
    .raddr_i(cnt_q[SEL_W-1:0]),
    .rdata_o(hold_rdata)
  );

  // buffer goes back to all ones as the last byte leaves
  assign hold_clear = (state_q == PMT_ST_PROG) && (cnt_q == CNT_END); // RULE_13
  assign prog_done_o = hold_clear;

  // walk the buffer once; read data trail the index by one cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      stage_vld_q <= 1'b0;
      stage_idx_q <= '0;
    end
    else if (state_q == PMT_ST_PROG)
    begin
      stage_vld_q <= (cnt_q != CNT_END);
      stage_idx_q <= cnt_q[SEL_W-1:0];
      if (cnt_q != CNT_END)
        cnt_q <= cnt_q + CNT_W'(1);
      else
        cnt_q <= '0;
    end
    else
    begin
      cnt_q <= '0;
      stage_vld_q <= 1'b0;
    end
  end

  // target block frozen at the start; low select bits do not take part
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      blk_q <= '0;
    else if (prog_take)
      blk_q <= ptr_q[`PMT_PTR_W-1:SEL_W]; // RULE_08
  end

  // all-ones bytes are skipped so the flash byte keeps its old value
  assign fl_wr_o = stage_vld_q && (hold_rdata != `PMT_ONES); // RULE_13
  assign fl_wr_data_o.cfg_space = blk_q[BLK_W-1]; // RULE_03
  assign fl_wr_data_o.byte_addr = {blk_q[BLK_W-2:0], stage_idx_q}; // RULE_08
  assign fl_wr_data_o.data = hold_rdata;

  // ************************************************************
  // block erase
  // ************************************************************

  // erase block is fixed at 64 bytes whatever the select width
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fl_erase_o <= 1'b0;
      fl_erase_block_o <= '0;
    end
    else
    begin
      fl_erase_o <= erase_take;
      if (erase_take)
        fl_erase_block_o <= ptr_q[`PMT_PTR_W-1:`PMT_ERASE_LSB]; // RULE_09
    end
  end

  // ************************************************************
  // status and register reads
  // ************************************************************

  // dirty: buffer written since the last program; set beats the clear
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      dirty_q <= 1'b0;
    else if (op_take && op_i.is_write)
      dirty_q <= 1'b1;
    else if (hold_clear)
      dirty_q <= 1'b0;
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= `PMT_ZERO8;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `PMT_OFS_PTR_LOW: reg_rdata_o <= ptr_q[7:0]; // RULE_01
        `PMT_OFS_PTR_HIGH: reg_rdata_o <= ptr_q[15:8]; // RULE_01
        `PMT_OFS_PTR_UPPER: reg_rdata_o <= {`PMT_UPPER_PAD, ptr_q[`PMT_PTR_W-1:16]}; // RULE_01
        `PMT_OFS_LATCH: reg_rdata_o <= latch_q; // RULE_12
        `PMT_OFS_STATUS: reg_rdata_o <= {5'h0, dirty_q, ptr_q[`PMT_CFG_BIT], !idle};
        default: reg_rdata_o <= `PMT_ZERO8;
      endcase
    end
    else
      reg_rdata_o <= `PMT_ZERO8;
  end

endmodule : pmt_table_unit
`default_nettype wire

// *** test/pmt_flash_model.sv ***
// flash array stand-in that answers word reads one cycle late
// assumes the unit holds its read address while fl_rd_o is high
`timescale 1ns/100ps
`default_nettype none

module pmt_flash_model
(
  // clock
  input wire logic clk_i,
  // read port
  input wire logic rd_i,
  input wire logic rd_cfg_i,
  input wire logic [19:0] rd_word_i,
  output logic [15:0] rdata_o
);
  // ****
  // read answer
  // ****
  // word content is a function of the address; between answers the bus
  // inverts every cycle so a sample one cycle late cannot pass by luck
  initial rdata_o = 16'h0000;
  always @(posedge clk_i)
  begin
    if (rd_i)
      rdata_o <= {rd_word_i[7:0] + 8'h11, rd_word_i[15:8] ^ rd_word_i[7:0]} ^ {16{rd_cfg_i}};
    else
      rdata_o <= ~rdata_o;
  end
endmodule : pmt_flash_model

`default_nettype wire

// *** test/pmt_table_unit_properties.sv ***
// port assertions for the table pointer unit
// assumes a bind onto pmt_table_unit, one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "pmt_cfg.svh"

module pmt_table_unit_properties
  import pmt_pkg::*;
#(
  parameter int SEL_W = `PMT_SEL_W
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register and op ports
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic op_valid_i,
  input wire pmt_op_s op_i,
  input wire logic op_ready_o,
  // program and flash ports
  input wire logic prog_start_i,
  input wire logic erase_start_i,
  input wire logic prog_done_o,
  input wire logic fl_rd_o,
  input wire logic fl_wr_o,
  input wire pmt_flash_wr_s fl_wr_data_o,
  input wire logic fl_erase_o,
  input wire logic [15:0] fl_erase_block_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ****
  // properties
  // ****
  property p_rdata_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
  property p_rd_go;
    op_valid_i && op_ready_o && !op_i.is_write |=> fl_rd_o && !op_ready_o;
  endproperty
  a_rd_go: assert property (p_rd_go) else $error("table read did not reach flash");
  property p_rd_back;
    fl_rd_o |=> !fl_rd_o && !op_ready_o ##1 op_ready_o;
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("table read length wrong");
  property p_wr_short;
    op_valid_i && op_ready_o && op_i.is_write |=> op_ready_o && !fl_rd_o && !fl_wr_o;
  endproperty
  a_wr_short: assert property (p_wr_short) else $error("table write touched flash");
  property p_prog_len;
    prog_start_i && op_ready_o && !op_valid_i |=> !op_ready_o ##64 prog_done_o;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("program length wrong");
  property p_done_idle;
    prog_done_o |=> op_ready_o && !fl_wr_o;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("unit busy after program");
  property p_ff_skip;
    fl_wr_o |-> fl_wr_data_o.data != 8'hff;
  endproperty
  a_ff_skip: assert property (p_ff_skip) else $error("all-ones byte strobed");
  property p_wr_step;
    fl_wr_o ##1 fl_wr_o |-> fl_wr_data_o.byte_addr == $past(fl_wr_data_o.byte_addr) + 21'h1;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("program byte address not in step");
  property p_erase_cause;
    fl_erase_o |-> $past(erase_start_i) && $past(op_ready_o);
  endproperty
  a_erase_cause: assert property (p_erase_cause) else $error("erase without request");
  property p_erase_hold;
    !fl_erase_o |-> $stable(fl_erase_block_o);
  endproperty
  a_erase_hold: assert property (p_erase_hold) else $error("erase block moved");
endmodule : pmt_table_unit_properties

bind pmt_table_unit pmt_table_unit_properties #(.SEL_W(SEL_W)) i_props (.clk_i(clk_i), .rst_i(rst_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .op_valid_i(op_valid_i), .op_i(op_i),
  .op_ready_o(op_ready_o), .prog_start_i(prog_start_i), .erase_start_i(erase_start_i),
  .prog_done_o(prog_done_o), .fl_rd_o(fl_rd_o), .fl_wr_o(fl_wr_o), .fl_wr_data_o(fl_wr_data_o),
  .fl_erase_o(fl_erase_o), .fl_erase_block_o(fl_erase_block_o));

`default_nettype wire

// *** test/pmt_table_unit_tb.sv ***
// self-checking bench for the table pointer unit
// assumes the flash model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
`include "pmt_cfg.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module pmt_table_unit_tb;
  import pmt_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic op_valid_i = 1'b0;
  logic prog_start_i = 1'b0;
  logic erase_start_i = 1'b0;
  pmt_op_s op_i = '0;
  logic [7:0] reg_rdata_o;
  logic op_ready_o, prog_done_o, fl_rd_o, fl_rd_cfg_o, fl_wr_o, fl_erase_o;
  logic [19:0] fl_rd_word_o;
  logic [15:0] fl_rdata_i, fl_erase_block_o;
  pmt_flash_wr_s fl_wr_data_o;
  pmt_flash_wr_s wr_q[$];
  logic [20:0] rd_seen;
  int n_mismatch = 0;
  int checks_done = 0;
  pmt_table_unit #(.SEL_W(6)) i_pmt_table_unit (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .op_valid_i(op_valid_i), .op_i(op_i), .op_ready_o(op_ready_o), .prog_start_i(prog_start_i),
    .erase_start_i(erase_start_i), .prog_done_o(prog_done_o), .fl_rd_o(fl_rd_o), .fl_rd_cfg_o(fl_rd_cfg_o),
    .fl_rd_word_o(fl_rd_word_o), .fl_rdata_i(fl_rdata_i), .fl_wr_o(fl_wr_o), .fl_wr_data_o(fl_wr_data_o),
    .fl_erase_o(fl_erase_o), .fl_erase_block_o(fl_erase_block_o));
  pmt_flash_model i_pmt_flash_model (.clk_i(clk_i), .rd_i(fl_rd_o), .rd_cfg_i(fl_rd_cfg_o),
    .rd_word_i(fl_rd_word_o), .rdata_o(fl_rdata_i));
  // ****
  // clock, monitors, helpers
  // ****
  initial forever #4 clk_i = ~clk_i;
  // record flash reads and byte writes as they happen
  always @(posedge clk_i)
  begin
    if (fl_rd_o === 1'b1)
      rd_seen <= {fl_rd_cfg_o, fl_rd_word_o};
    if (fl_wr_o === 1'b1)
      wr_q.push_back(fl_wr_data_o);
  end
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : reg_rd
  task automatic set_ptr(input logic [21:0] p);
    reg_wr(3'h2, {2'b00, p[21:16]});
    reg_wr(3'h1, p[15:8]);
    reg_wr(3'h0, p[7:0]);
  endtask : set_ptr
  task automatic get_ptr(output logic [21:0] p);
    logic [7:0] u, h, l;
    reg_rd(3'h2, u);
    reg_rd(3'h1, h);
    reg_rd(3'h0, l);
    p = {u[5:0], h, l};
  endtask : get_ptr
  // one table op; waits for ready so ops never overlap
  task automatic do_op(input logic w, input pmt_mode_e m);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i <= '{is_write: w, mode: m};
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    for (int n = 0; n < 8 && op_ready_o !== 1'b1; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    `CHK("op ready", 1'b1, op_ready_o)
  endtask : do_op
  function automatic logic [7:0] fl_byte(input logic [21:0] p);
    logic [15:0] w;
    w = {p[8:1] + 8'h11, p[16:9] ^ p[8:1]} ^ {16{p[21]}};
    return p[0] ? w[15:8] : w[7:0];
  endfunction : fl_byte
  function automatic logic [21:0] step(input logic [21:0] p, input logic [20:0] d);
    return {p[21], p[20:0] + d};
  endfunction : step
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  // hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end
  // ****
  // tests
  // ****
  initial
  begin
    logic [7:0] d;
    logic [21:0] p, e, q;
    logic [21:0] starts [3];
    starts = '{22'h00_1235, 22'h3f_ffff, 22'h20_0000};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a += 1)
    begin
      reg_rd(a[2:0], d);
      `CHK("reset value", 8'h00, d)
    end
    reg_wr(3'h2, 8'hff);
    reg_rd(3'h2, d);
    `CHK("upper byte", 8'h3f, d)
    $display("test registers done");
    // every mode from an odd pointer and from both wrap edges
    foreach (starts[s])
      for (int m = 0; m < 4; m++)
      begin
        p = starts[s];
        set_ptr(p);
        do_op(1'b0, pmt_mode_e'(m));
        e = (m == 3) ? step(p, 21'h1) : p;
        q = (m == 0) ? p : (m == 2) ? step(p, 21'h1f_ffff) : step(p, 21'h1);
        `CHK("read address", {e[21], e[20:1]}, rd_seen)
        reg_rd(3'h3, d);
        `CHK("latch byte", fl_byte(e), d)
        get_ptr(p);
        `CHK("pointer after", q, p)
      end
    $display("test reads done");
    reg_wr(3'h3, 8'ha5);
    set_ptr(22'h00_1043);
    do_op(1'b1, PMT_MODE_KEEP);
    reg_wr(3'h3, 8'h5c);
    set_ptr(22'h12_3485);
    do_op(1'b1, PMT_MODE_POST_INC);
    get_ptr(p);
    `CHK("pointer after write", 22'h12_3486, p)
    // next byte with post-decrement, so two buffer bytes sit side by side
    do_op(1'b1, PMT_MODE_POST_DEC);
    get_ptr(p);
    `CHK("pointer after dec write", 22'h12_3485, p)
    reg_wr(3'h3, 8'h00);
    set_ptr(22'h3f_ff07);
    do_op(1'b1, PMT_MODE_PRE_INC);
    reg_rd(3'h3, d);
    `CHK("latch after write", 8'h00, d)
    set_ptr(22'h00_107f);
    for (int r = 0; r < 2; r++)
    begin
      wr_q.delete();
      @(posedge clk_i);
      prog_start_i <= 1'b1;
      @(posedge clk_i);
      prog_start_i <= 1'b0;
      reg_rd(3'h4, d);
      `CHK("status busy", (r == 0) ? 8'h05 : 8'h01, d)
      repeat (70) @(posedge clk_i);
      `CHK("byte writes", (r == 0) ? 4 : 0, wr_q.size())
    end
    reg_rd(3'h4, d);
    `CHK("status after program", 8'h00, d)
    $display("test program done");
    set_ptr(22'h2a_bcde);
    @(posedge clk_i);
    erase_start_i <= 1'b1;
    @(posedge clk_i);
    erase_start_i <= 1'b0;
    #1;
    `CHK("erase strobe", 1'b1, fl_erase_o)
    `CHK("erase block", 16'haaf3, fl_erase_block_o)
    reg_rd(3'h4, d);
    `CHK("status space bit", 8'h02, d)
    $display("test erase done");
    end_of_test();
  end
  // program byte contents, kept apart so the expected table reads plainly
  initial
  begin
    wait (prog_done_o === 1'b1);
    #1;
    `CHK("byte 3", {1'b0, 15'h0041, 6'h03, 8'ha5}, wr_q[0])
    `CHK("byte 5", {1'b0, 15'h0041, 6'h05, 8'h5c}, wr_q[1])
    `CHK("byte 6", {1'b0, 15'h0041, 6'h06, 8'h5c}, wr_q[2])
    `CHK("byte 8", {1'b0, 15'h0041, 6'h08, 8'h00}, wr_q[3])
  end
endmodule : pmt_table_unit_tb

`default_nettype wire
